// *** core/ssru_defines.svh ***
// constants for the status and service request unit
`ifndef SSRU_DEFINES_SVH
`define SSRU_DEFINES_SVH
// status byte bit positions
`define SSRU_STATUS_OPSUM_BIT 7
`define SSRU_STATUS_SERVICE_BIT 6
`define SSRU_STATUS_EVSUM_BIT 5
`define SSRU_STATUS_MSGAVAIL_BIT 4
`define SSRU_STATUS_ERRQ_BIT 2
`define SSRU_STATUS_READY_BIT 0
// standard event bit positions
`define SSRU_EVENT_POWER_BIT 7
`define SSRU_EVENT_USER_BIT 6
`define SSRU_EVENT_CMDERR_BIT 5
`define SSRU_EVENT_EXECERR_BIT 4
`define SSRU_EVENT_DEVERR_BIT 3
`define SSRU_EVENT_QUERYERR_BIT 2
`define SSRU_EVENT_REQCTL_BIT 1
`define SSRU_EVENT_OPDONE_BIT 0
// bits that can ever read as one, and the status bits that can request service
`define SSRU_STATUS_USED 8'h75
`define SSRU_STATUS_SRQ_SRC 8'h35
`define SSRU_EVENT_USED 8'hfd
// reset values
`define SSRU_MASK_RST 8'h00
`define SSRU_EVENT_RST 8'h80
`endif

// *** core/ssru_pkg.sv ***
// types for the status and service request unit
`default_nettype none
package ssru_pkg;
   // what a register read port selects
   typedef enum logic [1:0] {
      SSRU_SEL_STATUS,
      SSRU_SEL_SRQ_MASK,
      SSRU_SEL_EVENTS,
      SSRU_SEL_EVENT_MASK
   } ssru_sel_t;
endpackage : ssru_pkg
`default_nettype wire

// *** core/ssru_status_unit.sv ***
// status byte, standard event register, enable masks and service request
`default_nettype none
`include "ssru_defines.svh"

// one enable mask: loads on its write strobe, clears at reset
module ssru_mask_reg #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // write port
   input wire logic wr_en,
   input wire logic [WIDTH-1:0] wr_data,
   // current mask
   output logic [WIDTH-1:0] mask
);
   import ssru_pkg::*;

   // masks clear at reset so nothing requests service until the host asks
   always_ff @(posedge clk) begin
      if (rst) begin
         mask <= WIDTH'(`SSRU_MASK_RST);
      end else if (wr_en) begin
         mask <= wr_data;
      end
   end
endmodule : ssru_mask_reg

module ssru_status_unit (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // device state levels
   input wire logic reply_queue_nonempty,
   input wire logic error_queue_nonempty,
   input wire logic ready_summary_in,
   // device event pulses
   input wire logic user_request_evt,
   input wire logic command_error_evt,
   input wire logic execution_error_evt,
   input wire logic device_error_evt,
   input wire logic query_error_evt,
   input wire logic operation_complete_evt,
   // register access from the command parser
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire ssru_pkg::ssru_sel_t reg_sel,
   input wire logic [7:0] reg_wdata,
   input wire logic clear_status,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   // ieee-488 interface
   input wire logic serial_poll,
   output logic srq,
   output logic [7:0] poll_byte,
   output logic poll_valid
);
   import ssru_pkg::*;

   // how the unit behaves, for whoever wires it to a command parser:
   // - every register access is a one-cycle strobe; a read answers on the next edge
   // - the event flags are sticky; a read returns the old value and clears them
   // - an event in the same cycle as a read or clear is kept for the next read
   // - the status byte is never stored, it is rebuilt from live levels each cycle
   // - the poll answer freezes requested-service as it stood before the poll
   // limitation: a cause that stays set re-raises srq one cycle after each poll,
   // so a host that polls in a tight loop sees a steady stream of requests

   // status byte layout as the host sees it:
   //   bit 7  operation summary, not implemented, always zero
   //   bit 6  master summary on a query, requested-service on a poll
   //   bit 5  event summary of the enabled standard event flags
   //   bit 4  message available while the reply queue holds a message
   //   bit 3  unused, zero
   //   bit 2  error queue not empty
   //   bit 1  unused, zero
   //   bit 0  ready summary, passed straight through
   // standard event flags, bit 7 down to 0: power-on, user request, command
   // error, execution error, device error, query error, request control (never
   // set) and operation complete

   // enable masks
   logic [7:0] srq_mask_reg;
   logic [7:0] event_mask_reg;

   // sticky event flags, their next value and what changes them
   logic [7:0] event_flags_reg;
   logic [7:0] event_flags_next;
   logic [7:0] event_set;
   logic event_clear;

   // requested-service flag, only meaningful on the bus port
   logic requested_service_flag_reg;

   // status byte pieces
   logic [7:0] status_base;
   logic event_summary_bit;
   logic master_summary_flag;
   logic [7:0] status_query;
   logic [7:0] status_poll;

   // register strobes decoded per target
   logic event_flags_read;
   logic srq_mask_write;
   logic event_mask_write;

   // event summary: any flag that is both set and enabled
   assign event_summary_bit = |(event_flags_reg & event_mask_reg);

   // status byte without bit 6; bit 7 and the unused bits stay zero
   always_comb begin
      status_base = 8'h00;
      status_base[`SSRU_STATUS_EVSUM_BIT] = event_summary_bit;
      status_base[`SSRU_STATUS_MSGAVAIL_BIT] = reply_queue_nonempty;
      status_base[`SSRU_STATUS_ERRQ_BIT] = error_queue_nonempty;
      status_base[`SSRU_STATUS_READY_BIT] = ready_summary_in;
      // the operation summary is left at zero on purpose
      status_base[`SSRU_STATUS_OPSUM_BIT] = 1'b0;
      status_base = status_base & `SSRU_STATUS_USED;
   end

   // bit 6 is masked out of the source set so it can never request
   // master summary is a pure function of live causes, so it cannot be written
   // and drops as soon as the causes are cleared
   assign master_summary_flag = |(status_base & srq_mask_reg & `SSRU_STATUS_SRQ_SRC);

   // query form carries master summary, poll form carries requested-service
   always_comb begin
      status_query = status_base;
      status_query[`SSRU_STATUS_SERVICE_BIT] = master_summary_flag;
      status_poll = status_base;
      status_poll[`SSRU_STATUS_SERVICE_BIT] = requested_service_flag_reg;
   end

   // register strobes; writes to the read-only registers fall through unused
   assign event_flags_read = reg_rd && (reg_sel == SSRU_SEL_EVENTS);
   assign srq_mask_write = reg_wr && (reg_sel == SSRU_SEL_SRQ_MASK);
   assign event_mask_write = reg_wr && (reg_sel == SSRU_SEL_EVENT_MASK);

   // service request enable mask
   ssru_mask_reg #(
      .WIDTH(8)
   ) srq_mask_inst (
      .clk(clk),
      .rst(rst),
      .wr_en(srq_mask_write),
      .wr_data(reg_wdata),
      .mask(srq_mask_reg)
   );

   // standard event enable mask
   ssru_mask_reg #(
      .WIDTH(8)
   ) event_mask_inst (
      .clk(clk),
      .rst(rst),
      .wr_en(event_mask_write),
      .wr_data(reg_wdata),
      .mask(event_mask_reg)
   );

   // gather the event pulses onto their flag positions; bit 7 and bit 1 have
   // no pulse here, power-on comes from reset and request control never sets
   always_comb begin
      event_set = 8'h00;
      event_set[`SSRU_EVENT_USER_BIT] = user_request_evt;
      event_set[`SSRU_EVENT_CMDERR_BIT] = command_error_evt;
      event_set[`SSRU_EVENT_EXECERR_BIT] = execution_error_evt;
      event_set[`SSRU_EVENT_DEVERR_BIT] = device_error_evt;
      event_set[`SSRU_EVENT_QUERYERR_BIT] = query_error_evt;
      event_set[`SSRU_EVENT_OPDONE_BIT] = operation_complete_evt;
      event_set[`SSRU_EVENT_REQCTL_BIT] = 1'b0;
   end

   // a read of the flags or a clear-status strobe empties the register
   assign event_clear = event_flags_read || clear_status;

   // event flags: sticky; a new event wins over a clear in the same cycle, so an
   // event that lands on the read edge is kept for the next read
   always_comb begin
      event_flags_next = event_flags_reg;
      if (event_clear) begin
         event_flags_next = 8'h00;
      end
      event_flags_next = event_flags_next | event_set;
      event_flags_next = event_flags_next & `SSRU_EVENT_USED;
   end

   // reset stands for the power cycle, so power-on reads set afterwards
   always_ff @(posedge clk) begin
      if (rst) begin
         event_flags_reg <= `SSRU_EVENT_RST;
      end else begin
         event_flags_reg <= event_flags_next;
      end
   end

   // requested-service latches with srq and drops after a poll; a still-pending
   // cause re-arms it next cycle, so no request is lost
   always_ff @(posedge clk) begin
      if (rst) begin
         requested_service_flag_reg <= 1'b0;
      end else if (serial_poll) begin
         requested_service_flag_reg <= 1'b0;
      end else if (master_summary_flag) begin
         requested_service_flag_reg <= 1'b1;
      end
   end

   // srq line follows the master summary; a serial-port host only polls
   // the poll edge forces it low for one cycle so the host sees the line drop
   always_ff @(posedge clk) begin
      if (rst) begin
         srq <= 1'b0;
      end else if (serial_poll) begin
         srq <= 1'b0;
      end else begin
         srq <= master_summary_flag;
      end
   end

   // serial poll strobe answer, one cycle after the poll
   always_ff @(posedge clk) begin
      if (rst) begin
         poll_valid <= 1'b0;
      end else begin
         poll_valid <= serial_poll;
      end
   end

   // serial poll byte, held until the next poll
   always_ff @(posedge clk) begin
      if (rst) begin
         poll_byte <= 8'h00;
      end else if (serial_poll) begin
         poll_byte <= status_poll;
      end
   end

   // register read strobe answer, one cycle after the read
   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
      end
   end

   // register read data, held until the next read; the flag read returns the
   // value from before the clear that the same strobe causes
   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         unique case (reg_sel)
            SSRU_SEL_STATUS: begin
               reg_rdata <= status_query;
            end
            SSRU_SEL_SRQ_MASK: begin
               reg_rdata <= srq_mask_reg;
            end
            SSRU_SEL_EVENTS: begin
               reg_rdata <= event_flags_reg;
            end
            SSRU_SEL_EVENT_MASK: begin
               reg_rdata <= event_mask_reg;
            end
         endcase
      end
   end
endmodule : ssru_status_unit
`default_nettype wire

// *** dv/ssru_status_unit_assertions.sv ***
// port checker for the status and service request unit
`default_nettype none
module ssru_status_unit_assertions (
   input wire logic clk, rst,
   input wire logic reg_rd, reg_wr, reg_rvalid, serial_poll, srq, poll_valid,
   input wire ssru_pkg::ssru_sel_t reg_sel,
   input wire logic [7:0] reg_wdata, reg_rdata, poll_byte
);
   timeunit 1ns;
   timeprecision 1ns;
   import ssru_pkg::*;
   logic [7:0] mask_q;
   // shadow of the request mask, srq is judged against it
   always_ff @(posedge clk) if (rst) mask_q <= 8'h00;
      else if (reg_wr && reg_sel == SSRU_SEL_SRQ_MASK) mask_q <= reg_wdata;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   read_answer_a: assert property (reg_rvalid == $past(reg_rd)) else $error("rvalid");
   poll_answer_a: assert property (poll_valid == $past(serial_poll)) else $error("pvalid");
   poll_rqs_a: assert property (serial_poll && srq |=> poll_byte[6]) else $error("rqs");
   poll_clears_a: assert property (serial_poll |=> !srq) else $error("srq kept");
   zero_bits_a: assert property (poll_valid |-> (poll_byte & 8'h8a) == 8'h00)
      else $error("unused bit set");
   srq_source_a: assert property (srq |-> (($past(mask_q) | $past(mask_q, 2)) & 8'h35) != 0)
      else $error("srq unmasked");
   rdata_hold_a: assert property (!$past(reg_rd) |-> $stable(reg_rdata)) else $error("rdata");
   poll_hold_a: assert property (!$past(serial_poll) |-> $stable(poll_byte)) else $error("pb");
   reset_quiet_a: assert property ($past(rst) |-> !srq && !reg_rvalid) else $error("rst");
endmodule : ssru_status_unit_assertions
bind ssru_status_unit ssru_status_unit_assertions ssru_status_unit_assertions_inst (
   .clk(clk), .rst(rst), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_rvalid(reg_rvalid),
   .serial_poll(serial_poll), .srq(srq), .poll_valid(poll_valid), .reg_sel(reg_sel),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .poll_byte(poll_byte));
`default_nettype wire

// *** dv/ssru_host_model.sv ***
// remote bus host: answers a service request with a serial poll
`default_nettype none
module ssru_host_model (
   input wire logic clk, rst, auto_en, srq, poll_valid,
   input wire logic [7:0] poll_byte,
   output logic serial_poll,
   output logic [7:0] last_poll
);
   timeunit 1ns;
   timeprecision 1ns;
   initial serial_poll = 1'b0;
   // one poll at a time, never while an answer is still due
   always @(negedge clk) serial_poll <= !rst && auto_en && srq && !serial_poll && !poll_valid;
   always @(posedge clk) if (poll_valid) last_poll <= poll_byte;
endmodule : ssru_host_model
`default_nettype wire

// *** dv/status_service_request_unit_bench.sv ***
// bench for the status and service request unit
`default_nettype none
module status_service_request_unit_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import ssru_pkg::*;
   logic clk = 0, rst = 1, rq = 0, eq = 0, rdy = 0, rd = 0, wr = 0, cs = 0, sp_b = 0, auto = 0;
   logic [5:0] ev = '0;
   logic [7:0] wd = '0, rdata, pbyte, last;
   ssru_sel_t sel = SSRU_SEL_STATUS;
   wire logic rv, srq, pv, sp_m;
   int err_count = 0, checked = 0, cyc = 0;
   initial forever #5 clk = ~clk;
   ssru_status_unit ssru_status_unit_inst (.clk(clk), .rst(rst), .reply_queue_nonempty(rq),
      .error_queue_nonempty(eq), .ready_summary_in(rdy), .user_request_evt(ev[5]),
      .command_error_evt(ev[4]), .execution_error_evt(ev[3]), .device_error_evt(ev[2]),
      .query_error_evt(ev[1]), .operation_complete_evt(ev[0]), .reg_rd(rd), .reg_wr(wr),
      .reg_sel(sel), .reg_wdata(wd), .clear_status(cs), .reg_rdata(rdata), .reg_rvalid(rv),
      .serial_poll(sp_b | sp_m), .srq(srq), .poll_byte(pbyte), .poll_valid(pv));
   ssru_host_model ssru_host_model_inst (.clk(clk), .rst(rst), .auto_en(auto), .srq(srq),
      .poll_valid(pv), .poll_byte(pbyte), .serial_poll(sp_m), .last_poll(last));
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   // one-cycle register access, read answer is due one cycle later
   task automatic acc(input logic w, input ssru_sel_t s, input logic [7:0] d);
      @(negedge clk);
      wr = w;
      rd = !w;
      sel = s;
      wd = d;
      @(negedge clk);
      wr = 1'b0;
      rd = 1'b0;
   endtask : acc
   task automatic rdc(input ssru_sel_t s, input logic [7:0] exp);
      acc(1'b0, s, 8'h00);
      cmp({7'h00, rv}, 8'h01);
      cmp(rdata, exp);
   endtask : rdc
   task automatic pulse(input logic [5:0] m, input logic p, input logic c);
      @(negedge clk) {ev, sp_b, cs} = {m, p, c};
      @(negedge clk) {ev, sp_b, cs} = '0;
   endtask : pulse
   task automatic conclude();
      $display("checked %0d err_count %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : conclude
   // watchdog, the run needs under a hundred cycles
   always @(posedge clk) if (++cyc == 3000) begin
      err_count++;
      conclude();
   end
   initial begin
      repeat (5) @(negedge clk);
      rst = 0;
      rdc(SSRU_SEL_SRQ_MASK, 8'h00);
      rdc(SSRU_SEL_EVENT_MASK, 8'h00);
      rdc(SSRU_SEL_EVENTS, 8'h80);
      rdc(SSRU_SEL_EVENTS, 8'h00);
      rdc(SSRU_SEL_STATUS, 8'h00);
      $display("reset test done");
      // every source lands on its own flag, bit 1 never sets
      for (int i = 0; i < 6; i++) begin
         pulse(6'h01 << i, 1'b0, 1'b0);
         rdc(SSRU_SEL_EVENTS, (i == 0) ? 8'h01 : 8'h02 << i);
      end
      $display("event test done");
      acc(1'b1, SSRU_SEL_EVENT_MASK, 8'h20);
      pulse(6'h10, 1'b0, 1'b0);
      rdc(SSRU_SEL_STATUS, 8'h20);
      acc(1'b1, SSRU_SEL_SRQ_MASK, 8'h40);
      acc(1'b1, SSRU_SEL_STATUS, 8'hff);
      rdc(SSRU_SEL_SRQ_MASK, 8'h40);
      cmp({7'h00, srq}, 8'h00);
      acc(1'b1, SSRU_SEL_SRQ_MASK, 8'h14);
      rq = 1;
      rdc(SSRU_SEL_STATUS, 8'h70);
      pulse(6'h00, 1'b1, 1'b0);
      cmp(pbyte, 8'h70);
      cmp({7'h00, srq}, 8'h00);
      {rq, eq} = 2'b01;
      rdc(SSRU_SEL_STATUS, 8'h64);
      eq = 0;
      rdc(SSRU_SEL_STATUS, 8'h20);
      pulse(6'h00, 1'b0, 1'b1);
      rdc(SSRU_SEL_EVENTS, 8'h00);
      $display("summary test done");
      acc(1'b1, SSRU_SEL_SRQ_MASK, 8'h01);
      {rdy, auto} = 2'b11;
      repeat (8) @(negedge clk);
      cmp(last, 8'h41);
      {rdy, auto} = 2'b00;
      $display("host poll test done");
      conclude();
   end
endmodule : status_service_request_unit_bench
`default_nettype wire
